/* File: pkg/iep_defines.svh */
/*
 Constants of the interrupt enable and priority block: register indices,
 bit positions, reset values and local register choices.
 Assumes it is included by bare name from design files.
*/
`ifndef IEP_DEFINES_SVH
`define IEP_DEFINES_SVH

// register indices; byte address on the bus is four times the index
`define IEP_IDX_MASK_MAIN      8'hA8
`define IEP_IDX_LEVEL_MAIN     8'hB8
`define IEP_IDX_MASK_EXT_ONE   8'hE6
`define IEP_IDX_MASK_EXT_TWO   8'hE7
`define IEP_IDX_LEVEL_EXT_ONE  8'hF6
`define IEP_IDX_LEVEL_EXT_TWO  8'hF7
`define IEP_IDX_BIT_ACCESS     8'h50
`define IEP_IDX_EVT_STATUS     8'h60
`define IEP_IDX_EVT_MASK       8'h61

// bit positions in the main mask register
`define IEP_BIT_GLOBAL_GATE    3'h7
`define IEP_BIT_SERIAL_PERIPH  3'h6
`define IEP_BIT_TIMER_TWO      3'h5
`define IEP_BIT_UART           3'h4
`define IEP_BIT_TIMER_ONE      3'h3
`define IEP_BIT_EXT_LINE_ONE   3'h2
`define IEP_BIT_TIMER_ZERO     3'h1
`define IEP_BIT_EXT_LINE_ZERO  3'h0

// bit access register fields
`define IEP_BA_TARGET_LSB      0
`define IEP_BA_BIT_LSB         8
`define IEP_BA_VALUE_BIT       11

// event status bit for a high request taken over a low service
`define IEP_EVT_PREEMPT        3'h7

// reset values
`define IEP_RST_MASK_MAIN      8'h00
`define IEP_RST_LEVEL_MAIN     8'h80
`define IEP_RST_EXT            8'h00
`define IEP_RST_EVT            8'h00

`endif

/* File: pkg/iep_pkg.sv */
/*
 Types of the interrupt enable and priority block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package iep_pkg;

   // request lines from the peripherals, all active high levels
   typedef struct packed {
      logic serial_periph_port;
      logic timer_two_high_overflow_flag;
      logic timer_two_low_overflow_flag;
      logic async_serial_port;
      logic timer_one_overflow_flag;
      logic external_line_one;
      logic timer_zero_overflow_flag;
      logic external_line_zero;
   } iep_src_s;

   // request presented to the core
   typedef struct packed {
      logic       req;
      logic       high;
      logic [2:0] src;
   } iep_core_s;

   // nesting of services in progress
   typedef enum logic [1:0] {
      SVC_IDLE,
      SVC_LOW,
      SVC_HIGH,
      SVC_LOW_HIGH
   } iep_svc_e;

endpackage : iep_pkg

`default_nettype wire

/* File: rtl/iep_top.sv */
/*
 Interrupt masking and two-level priority selection with an APB register
 slave, a sticky event status and one summary interrupt line.
 Assumes inputs synchronous to clk, an APB master with one transfer at a
 time, and a core that acks a presented request and pulses done on return.
*/
// Our own choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "iep_defines.svh"

// What this block does
// (R1) Global gate bit 7 low blocks every source; high lets each mask decide.
// (R2) Serial peripheral requests pass only while mask bit 6 is set.
// (R3) Timer two requests on either overflow flag pass while mask bit 5 set.
// (R4) UART request passes only while mask bit 4 is set.
// (R5) Timer one overflow passes only while mask bit 3 is set.
// (R6) External line one passes only while mask bit 2 is set.
// (R7) Timer zero overflow passes only while mask bit 1 is set.
// (R8) External line zero passes only while mask bit 0 is set.
// (R9) Main mask at index A8, all pages, single-bit access, resets to zero.
// (R10) Main level at index B8, all pages, bit access, writable bits reset low.
// (R11) Level bit 7 always reads one; writes to it are ignored.
// (R12) Level bit 6 sets serial peripheral priority high when one.
// (R13) Level bit 5 sets timer two priority high when one.
// (R14) Level bit 4 sets UART priority high when one.
// (R15) Level bit 3 sets timer one priority high when one.
// (R16) Level bit 2 sets external line one priority high when one.
// (R17) Level bit 1 sets timer zero priority high when one.
// (R18) Level bit 0 sets external line zero priority high when one.
// (R19) High requests go first, may preempt low service; equals never preempt.
module iep_top #(
   parameter int APB_AW = 12
) (
   input  wire logic             clk,       // 20 MHz system clock
   input  wire logic             rst_n,     // async reset, active low
   input  wire logic             psel,      // apb select
   input  wire logic             penable,   // apb access phase
   input  wire logic             pwrite,    // apb direction
   input  wire logic [APB_AW-1:0] paddr,    // apb byte address
   input  wire logic [31:0]      pwdata,    // apb write data
   input  wire logic [3:0]       pstrb,     // apb byte strobes
   output logic                  pready,    // apb ready
   output logic [31:0]           prdata,    // apb read data
   output logic                  pslverr,   // apb error, unmapped address
   input  wire iep_pkg::iep_src_s irq_src_in, // peripheral requests
   output iep_pkg::iep_core_s    core_irq,  // request to the core
   input  wire logic             irq_ack,   // core takes presented request
   input  wire logic             irq_done,  // core returns from a service
   output logic                  sys_irq    // summary of unmasked events
);

   localparam int WIW = APB_AW - 2;

   // index compare needs eight index bits above the byte offset
   if (APB_AW < 10 || APB_AW > 32) begin : g_bad_aw
      $error("iep_top: APB_AW must lie between 10 and 32");
   end

   logic [7:0]        interrupt_mask_main;
   logic [6:0]        level_bits;
   logic [7:0]        interrupt_mask_ext_one;
   logic [7:0]        interrupt_mask_ext_two;
   logic [7:0]        interrupt_level_ext_one;
   logic [7:0]        interrupt_level_ext_two;
   logic [7:0]        evt_status;
   logic [7:0]        evt_mask;
   iep_pkg::iep_svc_e svc;
   iep_pkg::iep_svc_e next_svc;
   iep_pkg::iep_core_s next_core_irq;

   // bus decode
   wire [WIW-1:0] widx      = paddr[APB_AW-1:2];
   wire hit_mask_main       = widx == WIW'(`IEP_IDX_MASK_MAIN);
   wire hit_level_main      = widx == WIW'(`IEP_IDX_LEVEL_MAIN);
   wire hit_mask_ext_one    = widx == WIW'(`IEP_IDX_MASK_EXT_ONE);
   wire hit_mask_ext_two    = widx == WIW'(`IEP_IDX_MASK_EXT_TWO);
   wire hit_level_ext_one   = widx == WIW'(`IEP_IDX_LEVEL_EXT_ONE);
   wire hit_level_ext_two   = widx == WIW'(`IEP_IDX_LEVEL_EXT_TWO);
   wire hit_bit_access      = widx == WIW'(`IEP_IDX_BIT_ACCESS);
   wire hit_evt_status      = widx == WIW'(`IEP_IDX_EVT_STATUS);
   wire hit_evt_mask        = widx == WIW'(`IEP_IDX_EVT_MASK);
   wire hit_any = hit_mask_main | hit_level_main | hit_mask_ext_one
                | hit_mask_ext_two | hit_level_ext_one | hit_level_ext_two
                | hit_bit_access | hit_evt_status | hit_evt_mask;

   // zero wait states: read data is captured during the setup cycle
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;

   wire wr_lo = psel & penable & pwrite & pstrb[0];
   wire rd_setup = psel & ~penable & ~pwrite;

   // bit access: one bit of the main mask or level set or cleared alone
   wire [7:0] ba_target = pwdata[`IEP_BA_TARGET_LSB +: 8];
   wire [2:0] ba_bit    = pwdata[`IEP_BA_BIT_LSB +: 3];
   wire       ba_value  = pwdata[`IEP_BA_VALUE_BIT];
   wire       ba_wr     = wr_lo & hit_bit_access;
   wire       ba_mask   = ba_wr & (ba_target == `IEP_IDX_MASK_MAIN);
   wire       ba_level  = ba_wr & (ba_target == `IEP_IDX_LEVEL_MAIN);
   wire [7:0] ba_onehot = 8'h01 << ba_bit;

   wire [7:0] mask_bit_res  = ba_value ? (interrupt_mask_main | ba_onehot)
                                       : (interrupt_mask_main & ~ba_onehot);
   wire [7:0] level_full    = {1'b1, level_bits};
   wire [7:0] level_bit_res = ba_value ? (level_full | ba_onehot)
                                       : (level_full & ~ba_onehot);

   wire [7:0] next_mask_main =
        (wr_lo & hit_mask_main) ? pwdata[7:0] :                         // R9
        ba_mask                 ? mask_bit_res : interrupt_mask_main;  // R9
   // bit 7 has no storage, so writes to it vanish
   wire [6:0] next_level_bits =
        (wr_lo & hit_level_main) ? pwdata[6:0] :                        // R10 R11
        ba_level                 ? level_bit_res[6:0] : level_bits;    // R10 R11

   // request vector in mask bit order
   wire [6:0] req_vec = {
      irq_src_in.serial_periph_port,
      irq_src_in.timer_two_low_overflow_flag
         | irq_src_in.timer_two_high_overflow_flag,                    // R3
      irq_src_in.async_serial_port,
      irq_src_in.timer_one_overflow_flag,
      irq_src_in.external_line_one,
      irq_src_in.timer_zero_overflow_flag,
      irq_src_in.external_line_zero
   };
   wire global_gate = interrupt_mask_main[`IEP_BIT_GLOBAL_GATE];

   logic [6:0] pend_high;
   logic [6:0] pend_low;
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_src
         // per source: global gate, own mask, then own level
         wire en = global_gate & interrupt_mask_main[g] & req_vec[g]; // R1 R2 R3 R4 R5 R6 R7 R8
         assign pend_high[g] = en & level_bits[g];       // R12 R13 R14 R15 R16 R17 R18
         assign pend_low[g]  = en & ~level_bits[g];      // R12 R13 R14 R15 R16 R17 R18
      end
   endgenerate

   // fixed order within one level: lowest bit first
   function automatic logic [2:0] lowest_set(input logic [6:0] v);
      logic [2:0] idx;
      idx = 3'd0;
      for (int i = 6; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : lowest_set

   // service nesting
   wire ack_take = core_irq.req & irq_ack;

   always_comb begin
      next_svc = svc;
      unique case (svc)
         iep_pkg::SVC_IDLE: begin
            if (ack_take) begin
               next_svc = core_irq.high ? iep_pkg::SVC_HIGH : iep_pkg::SVC_LOW;
            end
         end
         iep_pkg::SVC_LOW: begin
            if (ack_take) begin
               next_svc = iep_pkg::SVC_LOW_HIGH;                       // R19
            end else if (irq_done) begin
               next_svc = iep_pkg::SVC_IDLE;
            end
         end
         iep_pkg::SVC_HIGH: begin
            if (irq_done) begin
               next_svc = iep_pkg::SVC_IDLE;
            end
         end
         iep_pkg::SVC_LOW_HIGH: begin
            if (irq_done) begin
               next_svc = iep_pkg::SVC_LOW;
            end
         end
      endcase
   end

   // offer is judged against the nesting after this edge, so a taken
   // request is never offered twice at the same level
   wire high_ok = (next_svc == iep_pkg::SVC_IDLE) | (next_svc == iep_pkg::SVC_LOW);
   wire low_ok  = next_svc == iep_pkg::SVC_IDLE;
   wire offer_high = high_ok & (|pend_high);                           // R19
   wire offer_low  = low_ok & (|pend_low);

   always_comb begin
      next_core_irq.req  = offer_high | offer_low;
      next_core_irq.high = offer_high;                                  // R19
      next_core_irq.src  = offer_high ? lowest_set(pend_high)
                                      : lowest_set(pend_low);
   end

   // sticky events: bit per taken source plus preemption; set wins over clear
   wire [7:0] evt_set = ack_take
        ? ((8'h01 << core_irq.src)
           | ((svc == iep_pkg::SVC_LOW) ? (8'h01 << `IEP_EVT_PREEMPT) : 8'h00))
        : 8'h00;
   wire [7:0] evt_clr = (wr_lo & hit_evt_status) ? pwdata[7:0] : 8'h00;
   wire [7:0] next_evt_status = (evt_status & ~evt_clr) | evt_set;

   assign sys_irq = |(evt_status & evt_mask);

   // read mux; unmapped and bit access read zero
   wire [7:0] rd_byte =
        hit_mask_main     ? interrupt_mask_main :
        hit_level_main    ? level_full :                                // R11
        hit_mask_ext_one  ? interrupt_mask_ext_one :
        hit_mask_ext_two  ? interrupt_mask_ext_two :
        hit_level_ext_one ? interrupt_level_ext_one :
        hit_level_ext_two ? interrupt_level_ext_two :
        hit_evt_status    ? evt_status :
        hit_evt_mask      ? evt_mask : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_mask_main <= `IEP_RST_MASK_MAIN;                     // R9
         level_bits          <= 7'(`IEP_RST_LEVEL_MAIN);                // R10
      end else begin
         interrupt_mask_main <= next_mask_main;
         level_bits          <= next_level_bits;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_mask_ext_one  <= `IEP_RST_EXT;
         interrupt_mask_ext_two  <= `IEP_RST_EXT;
         interrupt_level_ext_one <= `IEP_RST_EXT;
         interrupt_level_ext_two <= `IEP_RST_EXT;
         evt_mask                <= `IEP_RST_EVT;
      end else begin
         if (wr_lo & hit_mask_ext_one)  interrupt_mask_ext_one  <= pwdata[7:0];
         if (wr_lo & hit_mask_ext_two)  interrupt_mask_ext_two  <= pwdata[7:0];
         if (wr_lo & hit_level_ext_one) interrupt_level_ext_one <= pwdata[7:0];
         if (wr_lo & hit_level_ext_two) interrupt_level_ext_two <= pwdata[7:0];
         if (wr_lo & hit_evt_mask)      evt_mask                <= pwdata[7:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         svc        <= iep_pkg::SVC_IDLE;
         core_irq   <= '0;
         evt_status <= `IEP_RST_EVT;
      end else begin
         svc        <= next_svc;
         core_irq   <= next_core_irq;
         evt_status <= next_evt_status;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= {24'h00_0000, rd_byte};
      end
   end

   // checks
   a_global_gate_off: assert property (@(posedge clk) disable iff (!rst_n) // R1
      !interrupt_mask_main[7] |=> !core_irq.req)
      else $error("request offered while global gate closed");

   a_src_mask_on: assert property (@(posedge clk) disable iff (!rst_n) // R2 R4 R5 R6 R7 R8
      core_irq.req |-> ($past(interrupt_mask_main) & (8'h01 << core_irq.src)) != 8'h00)
      else $error("offered source had its mask bit clear");

   a_timer_two_fwd: assert property (@(posedge clk) disable iff (!rst_n) // R3
      (svc == iep_pkg::SVC_IDLE && !irq_ack && !irq_done
       && interrupt_mask_main[7] && interrupt_mask_main[5]
       && (irq_src_in.timer_two_low_overflow_flag
           || irq_src_in.timer_two_high_overflow_flag))
      |=> core_irq.req)
      else $error("timer two request not offered");

   a_mask_bit_write: assert property (@(posedge clk) disable iff (!rst_n) // R9
      (ba_wr && ba_target == 8'hA8)
      |=> interrupt_mask_main[$past(ba_bit)] == $past(ba_value))
      else $error("single bit write of mask did not land");

   a_level_top_one: assert property (@(posedge clk) disable iff (!rst_n) // R11
      (rd_setup && hit_level_main) |=> prdata[7] && prdata[6:0] == $past(level_bits))
      else $error("level register read wrong");

   a_level_write: assert property (@(posedge clk) disable iff (!rst_n) // R10
      (wr_lo && hit_level_main) |=> level_bits == $past(pwdata[6:0]))
      else $error("level register write did not land");

   a_level_match: assert property (@(posedge clk) disable iff (!rst_n) // R12 R13 R14 R15 R16 R17 R18
      core_irq.req |-> core_irq.high == ((($past(level_bits) >> core_irq.src) & 7'h01) != 7'h00))
      else $error("offered level disagrees with level register");

   a_high_first: assert property (@(posedge clk) disable iff (!rst_n) // R19
      (core_irq.req && !core_irq.high) |-> $past(pend_high) == 7'h00)
      else $error("low offered while high pending");

   a_no_equal_nest: assert property (@(posedge clk) disable iff (!rst_n) // R19
      (core_irq.req && svc != iep_pkg::SVC_IDLE) |-> core_irq.high && svc == iep_pkg::SVC_LOW)
      else $error("request offered at an equal or lower level");

   a_evt_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      ack_take |=> (evt_status & (8'h01 << $past(core_irq.src))) != 8'h00)
      else $error("taken source did not set its event bit");

   a_unmapped_err: assert property (@(posedge clk) disable iff (!rst_n)
      (psel && penable) |-> pslverr == !hit_any)
      else $error("error answer disagrees with decode");

endmodule : iep_top

`default_nettype wire

/* File: tb/iep_core_model.sv */
/*
 Core-side partner of the interrupt block: takes each offered request with
 one ack, and returns from a service with one done pulse when told to.
 Assumes the block's core port: offers registered, ack taken at an edge.
*/
`timescale 1ns/100ps
`default_nettype none
module iep_core_model (
   input  wire logic               clk,       // system clock
   input  wire logic               rst_n,     // async reset, active low
   input  wire iep_pkg::iep_core_s core_irq,  // offer from the block
   input  wire logic               ack_en,    // take offers while high
   input  wire logic               done_req,  // one-cycle return request
   output logic                    irq_ack,   // take strobe
   output logic                    irq_done,  // return pulse
   output logic [3:0]              taken_src, // {high,src} of last take
   output logic [7:0]              taken_cnt  // number of takes
);
   wire logic take;
   assign take = irq_ack & core_irq.req;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_ack   <= 1'b0;
         irq_done  <= 1'b0;
         taken_src <= 4'h0;
         taken_cnt <= 8'h00;
      end else begin
         // drop after each take so one ack pairs with one service
         irq_ack  <= ack_en & core_irq.req & ~take;
         irq_done <= done_req;
         if (take) begin
            taken_src <= {core_irq.high, core_irq.src};
            taken_cnt <= taken_cnt + 8'h01;
         end
      end
   end
endmodule : iep_core_model
`default_nettype wire

/* File: tb/test_interrupt_enable_priority.sv */
/*
 Self-checking bench of the interrupt enable and priority block.
 Assumes the core partner model and an APB master written here.
*/
`timescale 1ns/100ps
`default_nettype none
module test_interrupt_enable_priority;
   logic               clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]        paddr = 12'h000;
   logic [31:0]        pwdata = 32'h0, prdata, rdv;
   logic [3:0]         pstrb = 4'h0, taken_src;
   logic               pready, pslverr, irq_ack, irq_done, sys_irq, errv;
   logic               ack_en = 1'b0, done_req = 1'b0;
   logic [3:0]         strb_v = 4'hF;
   logic [7:0]         taken_cnt;
   iep_pkg::iep_src_s  irq_src_in = '0;
   iep_pkg::iep_core_s core_irq;
   int                 n_mismatch = 0, cmp_count = 0;

   always #25 clk = ~clk;

   iep_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .irq_src_in(irq_src_in), .core_irq(core_irq), .irq_ack(irq_ack),
      .irq_done(irq_done), .sys_irq(sys_irq));
   iep_core_model core (.clk(clk), .rst_n(rst_n), .core_irq(core_irq), .ack_en(ack_en),
      .done_req(done_req), .irq_ack(irq_ack), .irq_done(irq_done), .taken_src(taken_src),
      .taken_cnt(taken_cnt));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= wd;
      pstrb   <= strb_v;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdv = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rdv, exp);
   endtask : rd

   task automatic core_is(input logic [4:0] exp);
      cyc(2);
      chk({27'h0, core_irq}, {27'h0, exp});
   endtask : core_is

   task automatic wait_taken(input logic [7:0] k);
      int i;
      i = 0;
      while (taken_cnt !== k && i < 50) begin
         @(posedge clk);
         i++;
      end
      chk({24'h0, taken_cnt}, {24'h0, k});
   endtask : wait_taken

   task automatic done_pulse;
      done_req <= 1'b1;
      cyc(1);
      done_req <= 1'b0;
      cyc(4);
   endtask : done_pulse

   task automatic t_regs;
      logic [7:0] ext [4] = '{8'hE6, 8'hE7, 8'hF6, 8'hF7};
      rd(8'hA8, 32'h00);
      rd(8'hB8, 32'h80);
      foreach (ext[i]) begin
         rd(ext[i], 32'h00);
         apb(1'b1, ext[i], 32'h5A);
         rd(ext[i], 32'h5A);
      end
      apb(1'b1, 8'hB8, 32'h7F);
      rd(8'hB8, 32'hFF);
      apb(1'b1, 8'hB8, 32'h00);
      rd(8'hB8, 32'h80);
      apb(1'b1, 8'hA8, 32'hA5);
      apb(1'b1, 8'h50, {20'h0, 1'b1, 3'h6, 8'hA8});
      apb(1'b1, 8'h50, {20'h0, 1'b0, 3'h0, 8'hA8});
      rd(8'hA8, 32'hE4);
      // low byte strobe off: the write must be dropped
      strb_v = 4'hE;
      apb(1'b1, 8'hA8, 32'hFF);
      strb_v = 4'hF;
      rd(8'hA8, 32'hE4);
      apb(1'b1, 8'h50, {20'h0, 1'b1, 3'h7, 8'hB8});
      apb(1'b1, 8'h50, {20'h0, 1'b1, 3'h2, 8'hB8});
      rd(8'hB8, 32'h84);
      apb(1'b1, 8'h10, 32'hFF);
      chk({31'h0, errv}, 32'h1);
      rd(8'h10, 32'h0);
      chk({31'h0, errv}, 32'h1);
      apb(1'b1, 8'hA8, 32'h00);
      apb(1'b1, 8'hB8, 32'h00);
      $display("test regs done");
   endtask : t_regs

   // struct bits 5 and 6 are both timer two flags under mask bit 5
   task automatic t_mask;
      logic [2:0] m;
      for (int b = 0; b < 8; b++) begin
         m = (b < 6) ? b[2:0] : b[2:0] - 3'h1;
         irq_src_in <= iep_pkg::iep_src_s'(8'h01 << b);
         apb(1'b1, 8'hA8, {24'h0, 8'h80 | (8'h01 << m)});
         core_is({1'b1, 1'b0, m});
         apb(1'b1, 8'hA8, {24'h0, 8'h01 << m});
         cyc(2);
         chk({31'h0, core_irq.req}, 32'h0);
         apb(1'b1, 8'hA8, {24'h0, 8'hFF ^ (8'h01 << m)});
         cyc(2);
         chk({31'h0, core_irq.req}, 32'h0);
      end
      irq_src_in <= '0;
      apb(1'b1, 8'hA8, 32'h00);
      $display("test mask done");
   endtask : t_mask

   task automatic t_level;
      irq_src_in <= iep_pkg::iep_src_s'(8'hFF);
      apb(1'b1, 8'hA8, 32'hFF);
      for (int m = 0; m < 7; m++) begin
         apb(1'b1, 8'hB8, {24'h0, 8'h01 << m});
         core_is({1'b1, 1'b1, m[2:0]});
      end
      apb(1'b1, 8'hB8, 32'h00);
      core_is({1'b1, 1'b0, 3'h0});
      irq_src_in <= '0;
      apb(1'b1, 8'hA8, 32'h00);
      $display("test level done");
   endtask : t_level

   task automatic t_nest;
      apb(1'b1, 8'hA8, 32'hFF);
      apb(1'b1, 8'hB8, 32'h40);
      ack_en <= 1'b1;
      irq_src_in <= iep_pkg::iep_src_s'(8'h01);
      wait_taken(8'h01);
      chk({28'h0, taken_src}, 32'h0);
      irq_src_in <= iep_pkg::iep_src_s'(8'h02);
      cyc(4);
      chk({24'h0, taken_cnt}, 32'h1);
      irq_src_in <= iep_pkg::iep_src_s'(8'h82);
      wait_taken(8'h02);
      chk({28'h0, taken_src}, 32'hE);
      irq_src_in <= iep_pkg::iep_src_s'(8'h02);
      rd(8'h60, 32'hC1);
      chk({31'h0, sys_irq}, 32'h0);
      apb(1'b1, 8'h61, 32'h80);
      cyc(1);
      chk({31'h0, sys_irq}, 32'h1);
      apb(1'b1, 8'h60, 32'h80);
      cyc(1);
      chk({31'h0, sys_irq}, 32'h0);
      rd(8'h60, 32'h41);
      done_pulse();
      chk({24'h0, taken_cnt}, 32'h2);
      done_pulse();
      wait_taken(8'h03);
      chk({28'h0, taken_src}, 32'h1);
      irq_src_in <= '0;
      done_pulse();
      ack_en <= 1'b0;
      apb(1'b1, 8'h60, 32'hFF);
      apb(1'b1, 8'h61, 32'h00);
      $display("test nest done");
   endtask : t_nest

   task automatic t_rst;
      apb(1'b1, 8'hA8, 32'hFF);
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      rd(8'hA8, 32'h00);
      $display("test reset done");
   endtask : t_rst

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_mask();
      t_level();
      t_nest();
      t_rst();
      final_report();
   end

   // whole run needs about 330 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule : test_interrupt_enable_priority
`default_nettype wire
